/* File: shared/smbcd_pkg.sv */
// ---------------------------------------------------------------------------
// smbus control/data register block: shared definitions
// ---------------------------------------------------------------------------
package smbcd_pkg;

  // special function register addresses
  localparam logic [7:0] CTL_ADDR = 8'hC0;
  localparam logic [7:0] DAT_ADDR = 8'hC2;

  // reset values
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] DAT_RST = 8'h00;
  localparam logic [7:0] RD_NONE = 8'h00;

  // bit counter landmarks inside a byte frame
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_STEP = 4'h1;

  // link-side tick divider default, in link clock cycles
  localparam int TICK_DIV_DEF = 8;

  // control/status register layout, bit 7 first
  typedef struct packed {
    logic master;                  // controller role
    logic transmit_direction_flag; // transmitter
    logic start_request;
    logic stop_request;
    logic acknowledge_request;
    logic arbitration_lost_flag;
    logic ack;                     // acknowledge level
    logic si;                      // interrupt flag, stalls the bus
  } smbcd_ctl_t;

  // register port request from the cpu
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } smbcd_sfr_req_t;

  // open-drain pin controls
  typedef struct packed {
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
  } smbcd_pin_drv_t;

  // engine states, gray along the start and transfer path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START_HOLD = 3'h1,
    ST_XFER_LOW = 3'h3,
    ST_XFER_HIGH = 3'h2,
    ST_STOP_A = 3'h6,
    ST_STOP_B = 3'h7,
    ST_RS_A = 3'h5,
    ST_RS_B = 3'h4
  } smbcd_state_t;

endpackage : smbcd_pkg

/* File: test/smbcd_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// port checks of the register block and its bus pins
// ---------------------------------------------------------------------------
module smbcd_asserts #(
  parameter int TICK_DIV = smbcd_pkg::TICK_DIV_DEF
) (
  input wire logic clk,                       // system clock
  input wire logic rst_n,                     // async reset, active low
  input wire logic link_clk,                  // bit-rate source clock
  input wire logic iface_enable,              // interface enable
  input wire logic free_timeout,              // free timeout pulse
  input wire smbcd_pkg::smbcd_sfr_req_t sfr,  // register access
  input wire logic [7:0] sfr_rdata,           // read data
  input wire logic scl_in,                    // clock pin level
  input wire logic sda_in,                    // data pin level
  input wire smbcd_pkg::smbcd_pin_drv_t pins  // open-drain controls
);
  localparam int TMAX = 8 * TICK_DIV + 16; // one tick plus sync, in clk cycles
  logic rd_q;
  logic seen_q;
  logic wr_q;
  logic [7:0] last_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // previous control read, and any control write or disable since then
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      seen_q <= 1'b0;
      wr_q <= 1'b0;
      last_q <= 8'h00;
    end else begin
      rd_q <= sfr.rd && (sfr.addr == smbcd_pkg::CTL_ADDR);
      if (rd_q) begin
        last_q <= sfr_rdata;
        seen_q <= 1'b1;
      end
      if ((sfr.wr && (sfr.addr == smbcd_pkg::CTL_ADDR)) || !iface_enable) begin
        wr_q <= 1'b1;
      end else if (rd_q) begin
        wr_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  property p_stall_scl;
    rd_q && !$past(sfr.wr) && sfr_rdata[7] && sfr_rdata[0] |-> pins.scl_oe;
  endproperty
  a_stall_scl: assert property (p_stall_scl)
    else $error("clock not held low while flag set");

  property p_si_sticky;
    rd_q && seen_q && !wr_q && last_q[0] |-> sfr_rdata[0];
  endproperty
  a_si_sticky: assert property (p_si_sticky)
    else $error("interrupt flag dropped without software");

  property p_sta_sticky;
    rd_q && seen_q && !wr_q && last_q[5] |-> sfr_rdata[5];
  endproperty
  a_sta_sticky: assert property (p_sta_sticky)
    else $error("start request dropped without software");

  property p_lost_flags;
    rd_q && sfr_rdata[2] |-> sfr_rdata[0];
  endproperty
  a_lost_flags: assert property (p_lost_flags)
    else $error("lost flag set with interrupt flag clear");

  property p_lost_mode;
    rd_q && sfr_rdata[2] |-> sfr_rdata[7:6] == 2'b00;
  endproperty
  a_lost_mode: assert property (p_lost_mode)
    else $error("lost arbitration without target receiver mode");

  property p_start_clock;
    $rose(pins.sda_oe) && !pins.scl_oe && !$past(pins.scl_oe) && scl_in |-> ##[1:TMAX] pins.scl_oe;
  endproperty
  a_start_clock: assert property (p_start_clock)
    else $error("start not followed by clock low");

  property p_stop_free;
    $fell(pins.sda_oe) && !pins.scl_oe && !$past(pins.scl_oe) |=> !pins.scl_oe [*4];
  endproperty
  a_stop_free: assert property (p_stop_free)
    else $error("clock pulled right after stop");

  property p_open_drain;
    pins.scl_out == 1'b0 && pins.sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("pin driven high");

  c_start: cover property ($rose(pins.sda_oe) && !pins.scl_oe && scl_in);
  c_stop: cover property ($fell(pins.sda_oe) && !pins.scl_oe && !$past(pins.scl_oe));
  c_lost: cover property (rd_q && sfr_rdata[2]);
endmodule : smbcd_asserts

bind smbcd_top smbcd_asserts #(.TICK_DIV(TICK_DIV)) u_asserts (
  .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .iface_enable(iface_enable),
  .free_timeout(free_timeout), .sfr(sfr), .sfr_rdata(sfr_rdata),
  .scl_in(scl_in), .sda_in(sda_in), .pins(pins));
`default_nettype wire

/* File: test/smbcd_target.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// behavioural bus target: takes bytes, acknowledges, may stretch the clock
// ---------------------------------------------------------------------------
module smbcd_target (
  input wire logic scl,         // resolved clock wire
  input wire logic sda,         // resolved data wire
  input wire logic ack_en,      // answer with acknowledge
  input wire logic slow,        // stretch clock after each byte
  output logic scl_low,         // pull clock low
  output logic sda_low,         // pull data low
  output logic [7:0] last_byte, // last byte received
  output var int stops          // stop conditions seen
);
  int bits = 0;
  logic [7:0] sh = 8'h00;
  realtime t_rise = 0;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    last_byte = 8'h00;
    stops = 0;
  end
  // data edges during a settled high clock are start and stop
  always @(negedge sda) if (scl && ($realtime - t_rise > 1.0)) bits = 0;
  always @(posedge sda) if (scl && ($realtime - t_rise > 1.0)) stops++;
  // sample just after the rising clock, msb first
  always @(posedge scl) begin
    t_rise = $realtime;
    #1;
    if (bits < 8) sh = {sh[6:0], sda};
    bits++;
    if (bits == 8) last_byte = sh;
  end
  // acknowledge through the ninth clock, then optionally stretch
  always @(negedge scl) begin
    sda_low = (bits == 8) && ack_en;
    if (bits == 9) begin
      bits = 0;
      if (slow) begin
        scl_low = 1'b1;
        #40 scl_low = 1'b0;
      end
    end
  end
endmodule : smbcd_target
`default_nettype wire

/* File: test/smbcd_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
// ---------------------------------------------------------------------------
// testbench: register access, transfers, arbitration loss, free timeout
// ---------------------------------------------------------------------------
module smbcd_tb_top;
  localparam int TDIV = 4;
  localparam logic [7:0] CTL = smbcd_pkg::CTL_ADDR;
  localparam logic [7:0] DAT = smbcd_pkg::DAT_ADDR;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic iface_enable = 1'b0;
  logic free_timeout = 1'b0;
  smbcd_pkg::smbcd_sfr_req_t sfr = '0;
  logic [7:0] sfr_rdata;
  smbcd_pkg::smbcd_pin_drv_t pins;
  logic scl;
  logic sda;
  logic jam = 1'b0;
  logic ack_en = 1'b1;
  logic slow = 1'b0;
  logic tgt_scl_low;
  logic tgt_sda_low;
  logic [7:0] tgt_byte;
  logic [7:0] rd_v;
  logic [7:0] d;
  int tgt_stops;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 32'hEA6D;
  int k;

  always #2 clk = ~clk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  // wired-and bus with pull-ups
  assign scl = ~(pins.scl_oe | tgt_scl_low);
  assign sda = ~(pins.sda_oe | tgt_sda_low | jam);

  smbcd_top #(.TICK_DIV(TDIV)) DUT (
    .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .iface_enable(iface_enable),
    .free_timeout(free_timeout), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .scl_in(scl), .sda_in(sda), .pins(pins));
  smbcd_target u_tgt (
    .scl(scl), .sda(sda), .ack_en(ack_en), .slow(slow), .scl_low(tgt_scl_low),
    .sda_low(tgt_sda_low), .last_byte(tgt_byte), .stops(tgt_stops));

  // ---------------------------------------------------------------------------
  // register access tasks
  // ---------------------------------------------------------------------------
  task step;
    @(posedge clk);
    #1;
  endtask : step
  task wr(input logic [7:0] a, input logic [7:0] v);
    sfr.addr = a;
    sfr.wdata = v;
    sfr.wr = 1'b1;
    step;
    sfr.wr = 1'b0;
    step;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] v);
    sfr.addr = a;
    sfr.rd = 1'b1;
    step;
    sfr.rd = 1'b0;
    step;
    v = sfr_rdata;
  endtask : rd
  task wait_ctl(input logic [7:0] m, input logic [7:0] v);
    int n;
    for (n = 0; n < 3000; n++) begin
      rd(CTL, rd_v);
      if ((rd_v & m) === v) break;
    end
  endtask : wait_ctl
  task results;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      results;
    end
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd(CTL, rd_v);
    `CHK(rd_v, smbcd_pkg::CTL_RST)
    rd(DAT, rd_v);
    `CHK(rd_v, smbcd_pkg::DAT_RST)
    rd(8'h55, rd_v);
    `CHK(rd_v, smbcd_pkg::RD_NONE)
    wr(CTL, 8'hCD);
    rd(CTL, rd_v);
    `CHK(rd_v, 8'h00)
    d = 8'($random(seed));
    wr(DAT, d);
    rd(DAT, rd_v);
    `CHK(rd_v, d)
    iface_enable = 1'b1;
    // acknowledged prompt transfer, then refused slow one with stop-start
    for (k = 0; k < 2; k++) begin
      ack_en = (k == 0);
      slow = (k == 1);
      wr(CTL, 8'h20);
      wait_ctl(8'h01, 8'h01);
      `CHK(rd_v & 8'hFD, 8'hE1)
      d = 8'($random(seed)) & 8'hFE;
      wr(DAT, d);
      wr(CTL, 8'h00);
      wait_ctl(8'h01, 8'h01);
      `CHK(rd_v, {6'b110000, ack_en, 1'b1})
      `CHK(tgt_byte, d)
      rd(DAT, rd_v);
      `CHK(rd_v, d)
      if (k == 1) begin
        wr(CTL, 8'h30);
        wait_ctl(8'h01, 8'h01);
        `CHK(rd_v & 8'hFD, 8'hE1)
      end
      wr(CTL, 8'h10);
      wait_ctl(8'h80, 8'h00);
      `CHK(rd_v & 8'hFD, 8'h40)
      `CHK(tgt_stops, 2 * k + 1)
    end
    // data line held low while the first bit is a one
    wr(CTL, 8'h20);
    wait_ctl(8'h01, 8'h01);
    wr(DAT, 8'hFF);
    wr(CTL, 8'h00);
    jam = 1'b1;
    wait_ctl(8'h01, 8'h01);
    `CHK(rd_v & 8'hC5, 8'h05)
    wait (scl === 1'b0);
    step;
    jam = 1'b0;
    wr(CTL, 8'h00);
    rd(CTL, rd_v);
    `CHK(rd_v & 8'h05, 8'h00)
    // start waits on the busy bus until the free timeout
    wr(CTL, 8'h20);
    repeat (40) step;
    rd(CTL, rd_v);
    `CHK(rd_v[7], 1'b0)
    free_timeout = 1'b1;
    step;
    free_timeout = 1'b0;
    // free timeout acts as a stop: flag and stop request rise, start waits on the flag
    wait_ctl(8'h01, 8'h01);
    `CHK(rd_v & 8'h91, 8'h11)
    wr(CTL, 8'h20);
    wait_ctl(8'h81, 8'h81);
    `CHK(rd_v[7], 1'b1)
    wr(CTL, 8'h10);
    wait_ctl(8'h80, 8'h00);
    `CHK(rd_v[4], 1'b0)
    results;
  end
endmodule : smbcd_tb_top
`default_nettype wire

/* File: verilog/smbcd_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// two-flop synchroniser
// ---------------------------------------------------------------------------
module smbcd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,          // destination clock
  input wire logic rst_n,        // async reset, active low
  input wire logic [W-1:0] d,    // asynchronous input
  output logic [W-1:0] q         // synchronised output
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } smbcd_sync_t;

  smbcd_sync_t r, n;

  // first stage feeds only the second
  always_comb begin
    n = r;
    n.s1 = d;
    n.s2 = r.s1;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= {RST_VAL, RST_VAL};
    end else begin
      r <= n;
    end
  end

  assign q = r.s2;

endmodule : smbcd_sync
`default_nettype wire

/* File: verilog/smbcd_top.sv */
`timescale 1ns/10ps
`default_nettype none
module smbcd_top #(
  parameter int TICK_DIV = smbcd_pkg::TICK_DIV_DEF
) (
  input wire logic clk,                       // system clock
  input wire logic rst_n,                     // async reset, active low
  input wire logic link_clk,                  // bit-rate source clock
  input wire logic iface_enable,              // interface enable level
  input wire logic free_timeout,              // free timeout pulse
  input wire smbcd_pkg::smbcd_sfr_req_t sfr,  // register access
  output logic [7:0] sfr_rdata,               // registered read data
  input wire logic scl_in,                    // scl pin level
  input wire logic sda_in,                    // sda pin level
  output smbcd_pkg::smbcd_pin_drv_t pins      // open-drain controls
);

  // ---------------------------------------------------------------------------
  // link domain: bit-rate tick as a toggle
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cnt;
    logic tgl;
  } smbcd_link_t;

  smbcd_link_t lr, ln;

  // divider flips the toggle once per tick period
  always_comb begin
    ln = lr;
    if (lr.cnt == 16'(TICK_DIV - 1)) begin
      ln.cnt = 16'h0000;
      ln.tgl = ~lr.tgl;
    end else begin
      ln.cnt = lr.cnt + 16'h0001;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lr <= '0;
    end else begin
      lr <= ln;
    end
  end

  // ---------------------------------------------------------------------------
  // crossing of pins and tick toggle into clk
  // ---------------------------------------------------------------------------
  logic [2:0] sync_q;
  logic scl_s;
  logic sda_s;
  logic tick_s;

  smbcd_sync #(
    .W(3),
    .RST_VAL(3'h6)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({scl_in, sda_in, lr.tgl}),
    .q(sync_q)
  );

  assign scl_s = sync_q[2];
  assign sda_s = sync_q[1];
  assign tick_s = sync_q[0];

  // ---------------------------------------------------------------------------
  // system domain state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    smbcd_pkg::smbcd_state_t st;
    smbcd_pkg::smbcd_ctl_t ctl;
    logic [7:0] dat;
    logic [7:0] rdata;
    logic [3:0] bitcnt;
    logic scl_low;
    logic scl_oe;
    logic sda_drv;
    logic busy;
    logic addressed;
    logic addr_phase;
    logic ignore;
    logic wr_pend;
    logic scl_q;
    logic sda_q;
    logic tick_q;
  } smbcd_reg_t;

  smbcd_reg_t r, n;
  logic tick;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic lose;
  logic txm;

  // register access, bus watch and bit engine
  always_comb begin
    n = r;
    lose = 1'b0;
    txm = r.ctl.transmit_direction_flag;
    tick = r.tick_q ^ tick_s;
    scl_rise = scl_s & ~r.scl_q;
    scl_fall = ~scl_s & r.scl_q;
    start_det = scl_s & r.scl_q & r.sda_q & ~sda_s;
    stop_det = scl_s & r.scl_q & ~r.sda_q & sda_s;
    n.tick_q = tick_s;
    n.scl_q = scl_s;
    n.sda_q = sda_s;

    // software writes, read-only bits untouched
    if (sfr.wr) begin
      if (sfr.addr == smbcd_pkg::CTL_ADDR) begin
        n.ctl.start_request = sfr.wdata[5];
        n.ctl.stop_request = sfr.wdata[4];
        n.ctl.ack = sfr.wdata[1];
        if (!sfr.wdata[0]) begin
          n.ctl.si = 1'b0;
          n.ctl.arbitration_lost_flag = 1'b0;
        end
      end else if (sfr.addr == smbcd_pkg::DAT_ADDR) begin
        n.dat = sfr.wdata;
        n.wr_pend = 1'b1;
      end
    end

    // registered read data
    if (sfr.rd) begin
      if (sfr.addr == smbcd_pkg::CTL_ADDR) begin
        n.rdata = r.ctl;
      end else if (sfr.addr == smbcd_pkg::DAT_ADDR) begin
        n.rdata = r.dat;
      end else begin
        n.rdata = smbcd_pkg::RD_NONE;
      end
    end

    if (!iface_enable) begin
      n.st = smbcd_pkg::ST_IDLE;
      n.scl_low = 1'b0;
      n.sda_drv = 1'b0;
      n.busy = 1'b0;
      n.ctl.master = 1'b0;
    end else begin
      // start seen on the bus
      if (start_det) begin
        n.busy = 1'b1;
        if (!r.ctl.master) begin
          n.ctl.transmit_direction_flag = 1'b0;
          n.bitcnt = smbcd_pkg::BIT_FIRST;
          n.addr_phase = 1'b1;
          n.addressed = 1'b0;
          n.ignore = 1'b0;
        end else if (!r.ctl.start_request && r.st != smbcd_pkg::ST_START_HOLD) begin
          lose = 1'b1;
        end
      end

      // stop or free timeout seen on the bus
      if (stop_det || free_timeout) begin
        n.busy = 1'b0;
        if (r.ctl.master) begin
          lose = 1'b1;
          n.ctl.stop_request = 1'b1;
        end else if (r.addressed || free_timeout) begin
          n.ctl.stop_request = 1'b1;
          n.ctl.si = 1'b1;
          n.addressed = 1'b0;
        end
      end

      case (r.st)
        smbcd_pkg::ST_IDLE: begin
          if (tick && r.ctl.start_request && !r.busy && !r.ctl.master && !r.ctl.si) begin
            n.sda_drv = 1'b1;
            n.st = smbcd_pkg::ST_START_HOLD;
          end else if (r.busy && !r.ignore && !r.ctl.master) begin
            // target follows the bus clock
            if (scl_rise) begin
              if (r.bitcnt <= smbcd_pkg::BIT_LAST) begin
                n.dat = {r.dat[6:0], sda_s};
                if (r.bitcnt == smbcd_pkg::BIT_FIRST) begin
                  n.wr_pend = 1'b0;
                end
                if (r.ctl.transmit_direction_flag && !r.sda_drv && !sda_s) begin
                  lose = 1'b1;
                end
              end else if (r.ctl.transmit_direction_flag) begin
                n.ctl.ack = ~sda_s;
              end
            end
            if (scl_fall) begin
              if (r.bitcnt == smbcd_pkg::BIT_LAST) begin
                n.bitcnt = smbcd_pkg::BIT_ACK;
                n.sda_drv = 1'b0;
                if (!r.ctl.transmit_direction_flag) begin
                  n.ctl.acknowledge_request = 1'b1;
                  n.ctl.ack = 1'b0;
                  n.ctl.si = 1'b1;
                  if (r.addr_phase) begin
                    n.ctl.start_request = 1'b1;
                  end
                end
              end else if (r.bitcnt == smbcd_pkg::BIT_ACK) begin
                n.bitcnt = smbcd_pkg::BIT_FIRST;
                n.ctl.acknowledge_request = 1'b0;
                n.sda_drv = 1'b0;
                if (r.ctl.transmit_direction_flag) begin
                  n.ctl.si = 1'b1;
                end
                if (r.addr_phase) begin
                  n.addr_phase = 1'b0;
                  n.addressed = r.ctl.ack;
                  n.ignore = ~r.ctl.ack;
                end
              end else begin
                n.bitcnt = r.bitcnt + smbcd_pkg::BIT_STEP;
              end
            end
            // drive next bit while scl is low and not stalled
            if (!scl_s && !scl_fall && !r.ctl.si) begin
              if (r.bitcnt == smbcd_pkg::BIT_FIRST && !r.addr_phase) begin
                n.ctl.transmit_direction_flag = r.wr_pend;
                txm = r.wr_pend;
              end
              if (r.bitcnt <= smbcd_pkg::BIT_LAST) begin
                n.sda_drv = txm & ~r.dat[7];
              end else begin
                n.sda_drv = ~txm & r.ctl.ack;
              end
            end
          end
        end

        smbcd_pkg::ST_START_HOLD: begin
          if (tick) begin
            n.scl_low = 1'b1;
            n.ctl.master = 1'b1;
            n.ctl.transmit_direction_flag = 1'b1;
            n.ctl.si = 1'b1;
            n.bitcnt = smbcd_pkg::BIT_FIRST;
            n.addr_phase = 1'b0;
            n.st = smbcd_pkg::ST_XFER_LOW;
          end
        end

        smbcd_pkg::ST_XFER_LOW: begin
          if (tick && !r.ctl.si) begin
            if (r.bitcnt == smbcd_pkg::BIT_FIRST && r.ctl.stop_request) begin
              n.sda_drv = 1'b1;
              n.st = smbcd_pkg::ST_STOP_A;
            end else if (r.bitcnt == smbcd_pkg::BIT_FIRST && r.ctl.start_request) begin
              n.sda_drv = 1'b0;
              n.st = smbcd_pkg::ST_RS_A;
            end else begin
              if (r.bitcnt == smbcd_pkg::BIT_FIRST) begin
                txm = r.wr_pend;
                n.ctl.transmit_direction_flag = r.wr_pend;
                n.wr_pend = 1'b0;
              end
              if (r.bitcnt <= smbcd_pkg::BIT_LAST) begin
                n.sda_drv = txm & ~r.dat[7];
              end else begin
                n.sda_drv = ~txm & r.ctl.ack;
              end
              n.scl_low = 1'b0;
              n.st = smbcd_pkg::ST_XFER_HIGH;
            end
          end
        end

        smbcd_pkg::ST_XFER_HIGH: begin
          if (tick && scl_s) begin
            if (r.bitcnt <= smbcd_pkg::BIT_LAST) begin
              n.dat = {r.dat[6:0], sda_s};
              if (r.ctl.transmit_direction_flag && !r.sda_drv && !sda_s) begin
                lose = 1'b1;
              end
            end else if (r.ctl.transmit_direction_flag) begin
              n.ctl.ack = ~sda_s;
            end
            n.scl_low = 1'b1;
            n.st = smbcd_pkg::ST_XFER_LOW;
            if (r.bitcnt == smbcd_pkg::BIT_LAST) begin
              n.bitcnt = smbcd_pkg::BIT_ACK;
              if (!r.ctl.transmit_direction_flag) begin
                n.ctl.acknowledge_request = 1'b1;
                n.ctl.ack = 1'b0;
                n.ctl.si = 1'b1;
              end
            end else if (r.bitcnt == smbcd_pkg::BIT_ACK) begin
              n.bitcnt = smbcd_pkg::BIT_FIRST;
              n.ctl.acknowledge_request = 1'b0;
              if (r.ctl.transmit_direction_flag) begin
                n.ctl.si = 1'b1;
              end
            end else begin
              n.bitcnt = r.bitcnt + smbcd_pkg::BIT_STEP;
            end
          end
        end

        smbcd_pkg::ST_STOP_A: begin
          if (tick) begin
            n.scl_low = 1'b0;
            n.st = smbcd_pkg::ST_STOP_B;
          end
        end

        smbcd_pkg::ST_STOP_B: begin
          if (tick) begin
            if (!scl_s) begin
              lose = 1'b1;
            end else begin
              n.sda_drv = 1'b0;
              n.ctl.stop_request = 1'b0;
              n.ctl.master = 1'b0;
              n.st = smbcd_pkg::ST_IDLE;
            end
          end
        end

        smbcd_pkg::ST_RS_A: begin
          if (tick) begin
            n.scl_low = 1'b0;
            n.st = smbcd_pkg::ST_RS_B;
          end
        end

        smbcd_pkg::ST_RS_B: begin
          if (tick) begin
            if (!scl_s) begin
              lose = 1'b1;
            end else begin
              n.sda_drv = 1'b1;
              n.st = smbcd_pkg::ST_START_HOLD;
            end
          end
        end

        default: begin
          n.st = smbcd_pkg::ST_IDLE;
        end
      endcase

      // lost arbitration: drop to target receiver, byte kept
      if (lose) begin
        n.ctl.arbitration_lost_flag = 1'b1;
        n.ctl.si = 1'b1;
        n.ctl.master = 1'b0;
        n.ctl.transmit_direction_flag = 1'b0;
        n.sda_drv = 1'b0;
        n.scl_low = 1'b0;
        n.st = smbcd_pkg::ST_IDLE;
      end
    end

    // scl held low while stalled on the interrupt flag
    n.scl_oe = iface_enable & (n.scl_low | (n.ctl.si & n.busy));
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{st: smbcd_pkg::ST_IDLE, ctl: smbcd_pkg::CTL_RST, dat: smbcd_pkg::DAT_RST,
             rdata: smbcd_pkg::RD_NONE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign sfr_rdata = r.rdata;
  assign pins = '{scl_out: 1'b0, scl_oe: r.scl_oe, sda_out: 1'b0, sda_oe: r.sda_drv};

endmodule : smbcd_top
`default_nettype wire
